// ### sgc_pkg.sv
// Package for the switchgear object control block.
// Assumes a 100 MHz clock; all timing counts derive from it.
package sgc_pkg;
	localparam int NUM_OBJ = 8;
	localparam int CLK_HZ = 100_000_000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
	// Time settings are given in milliseconds; 20 ms to 600 s
	localparam int TIME_W = 20;
	localparam logic [TIME_W-1:0] TIME_MIN_MS = 20'h00014;
	localparam logic [TIME_W-1:0] TIME_MAX_MS = 20'h927C0;
	localparam int RELEASE_PULSE_MS = 1000;
	localparam int MIN_DI_PULSE_MS = 60;
	localparam int MS_CNT_W = 17;
	localparam logic [MS_CNT_W-1:0] MS_TICK_LAST = MS_CNT_W'(CYC_PER_MS - 1);
	localparam logic [TIME_W-1:0] RELEASE_PULSE_DEF = TIME_W'(RELEASE_PULSE_MS);
	localparam int IDX_W = 3;
	typedef logic [1:0] sgc_pos_t;
	localparam sgc_pos_t POS_UNDEF00 = 2'h0;
	localparam sgc_pos_t POS_OPEN = 2'h1;
	localparam sgc_pos_t POS_CLOSED = 2'h2;
	localparam sgc_pos_t POS_UNDEF11 = 2'h3;
	typedef enum logic [1:0] {SGC_IDLE, SGC_OPENING, SGC_CLOSING, SGC_READY_WAIT} sgc_obj_e;

	function automatic sgc_pos_t sgc_decode(input logic open_in, input logic close_in);
		unique case ({close_in, open_in})
			2'b01: sgc_decode = POS_OPEN;
			2'b10: sgc_decode = POS_CLOSED;
			2'b11: sgc_decode = POS_UNDEF11;
			default: sgc_decode = POS_UNDEF00;
		endcase
	endfunction
endpackage

// ### sgc_obj_if.sv
// Carrier between the arbiter and one object's sequencer.
// Assumes the arbiter drives commands as single-cycle pulses.
`timescale 1ns/100ps
interface sgc_obj_if;
	logic cmd_open;
	logic cmd_close;
	logic ms_tick;
	logic [sgc_pkg::TIME_W-1:0] max_pulse_ms;
	logic [sgc_pkg::TIME_W-1:0] compl_ms;
	logic ready_assigned;
	logic open_status_input;
	logic close_status_input;
	logic ready_status_input;
	logic open_out;
	logic close_out;
	logic fail;
	logic undef_event;
	sgc_pkg::sgc_pos_t pos;
	modport ctrl (output cmd_open, cmd_close, ms_tick, max_pulse_ms, compl_ms, ready_assigned,
		open_status_input, close_status_input, ready_status_input,
		input open_out, close_out, fail, undef_event, pos);
	modport obj (input cmd_open, cmd_close, ms_tick, max_pulse_ms, compl_ms, ready_assigned,
		open_status_input, close_status_input, ready_status_input,
		output open_out, close_out, fail, undef_event, pos);
endinterface

// ### sgc_object.sv
// One switchgear object: position decode, bounded command pulse, timeouts.
// Assumes status inputs are already synchronised by the parent.
`timescale 1ns/100ps
module sgc_object (
	input wire logic clk,
	input wire logic rst_n,
	sgc_obj_if.obj bus
);
	typedef struct packed {
		sgc_pkg::sgc_obj_e st;
		logic [sgc_pkg::TIME_W-1:0] ms;
		sgc_pkg::sgc_pos_t start_pos;
		logic fail;
		logic undef_event;
	} sgc_object_s;
	sgc_object_s r, next_r;
	sgc_pkg::sgc_pos_t pos;

	assign pos = sgc_pkg::sgc_decode(bus.open_status_input, bus.close_status_input); // RULE5

	always_comb begin
		next_r = r;
		next_r.undef_event = 1'b0;
		if (bus.ms_tick) begin
			next_r.ms = r.ms + 20'h00001;
		end
		unique case (r.st)
			sgc_pkg::SGC_IDLE: begin
				next_r.ms = '0;
				next_r.start_pos = pos;
				if (bus.cmd_open && pos != sgc_pkg::POS_OPEN) begin
					next_r.st = sgc_pkg::SGC_OPENING;
					next_r.fail = 1'b0;
				end else if (bus.cmd_close && pos != sgc_pkg::POS_CLOSED) begin
					next_r.st = sgc_pkg::SGC_CLOSING;
					next_r.fail = 1'b0;
				end
			end
			sgc_pkg::SGC_OPENING, sgc_pkg::SGC_CLOSING: begin
				// Pulse ends as soon as position moves away from where it began
				if (pos != r.start_pos) begin // RULE6
					next_r.ms = '0;
					next_r.st = bus.ready_assigned ? sgc_pkg::SGC_READY_WAIT
						: sgc_pkg::SGC_IDLE; // RULE8
				end else if (r.ms >= bus.max_pulse_ms) begin
					next_r.st = sgc_pkg::SGC_IDLE;
					next_r.fail = 1'b1; // RULE7
					next_r.undef_event = 1'b1; // RULE7
				end
			end
			sgc_pkg::SGC_READY_WAIT: begin
				if (bus.ready_status_input) begin
					next_r.st = sgc_pkg::SGC_IDLE;
				end else if (r.ms >= bus.compl_ms) begin
					next_r.st = sgc_pkg::SGC_IDLE;
					next_r.fail = 1'b1; // RULE21
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{st: sgc_pkg::SGC_IDLE, ms: '0, start_pos: sgc_pkg::POS_UNDEF00,
				fail: 1'b0, undef_event: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign bus.open_out = (r.st == sgc_pkg::SGC_OPENING); // RULE9
	assign bus.close_out = (r.st == sgc_pkg::SGC_CLOSING); // RULE9
	assign bus.fail = r.fail;
	assign bus.undef_event = r.undef_event;
	assign bus.pos = pos;

	property p_pulse_bounded;
		@(posedge clk) disable iff (!rst_n)
		(r.st == sgc_pkg::SGC_OPENING && pos == r.start_pos && r.ms >= bus.max_pulse_ms)
			|=> !bus.open_out && bus.fail && bus.undef_event;
	endproperty
	a_pulse_bounded: assert property (p_pulse_bounded) else $error("pulse not ended at limit"); // RULE7

	property p_early_stop;
		@(posedge clk) disable iff (!rst_n)
		(bus.close_out && pos != r.start_pos) |=> !bus.close_out;
	endproperty
	a_early_stop: assert property (p_early_stop) else $error("pulse not ended on move"); // RULE6

	property p_ready_timeout;
		@(posedge clk) disable iff (!rst_n)
		(r.st == sgc_pkg::SGC_READY_WAIT && !bus.ready_status_input && r.ms >= bus.compl_ms)
			|=> bus.fail;
	endproperty
	a_ready_timeout: assert property (p_ready_timeout) else $error("ready timeout missed"); // RULE21

	property p_no_ready_wait;
		@(posedge clk) disable iff (!rst_n)
		!bus.ready_assigned |-> r.st != sgc_pkg::SGC_READY_WAIT || $past(bus.ready_assigned);
	endproperty
	a_no_ready_wait: assert property (p_no_ready_wait) else $error("ready wait unassigned"); // RULE8

	property p_pos_code;
		@(posedge clk) disable iff (!rst_n)
		(bus.open_status_input && !bus.close_status_input) |-> bus.pos == sgc_pkg::POS_OPEN;
	endproperty
	a_pos_code: assert property (p_pos_code) else $error("position decode wrong"); // RULE5
endmodule

// ### sgc_top.sv
// Switchgear object control: eight objects, command arbitration, latch release.
// Assumes all *_in pins are asynchronous; settings come from same-clock logic.
//
// Notes on behaviour
// RULE1: First function key, if selected, fires a latch-release pulse of set length.
// RULE2: Release pulse acts only while some latched output is active.
// RULE3: Eight objects, each in select-before-operate or direct control.
// RULE4: Actuator fault output asserts when any object operation fails to complete.
// RULE5: Position is 00 undefined, open, closed or 11 undefined from status inputs.
// RULE6: Command pulses stop at max pulse time or once object changes state.
// RULE7: No state change in max pulse time sets fault and undefined event.
// RULE8: Completion timeout only supervises ready; ignored with no ready input assigned.
// RULE9: Each object has own open and close pulse outputs for any command source.
// RULE10: Local state ignores remote inputs; remote state ignores local inputs.
// RULE11: Digital command inputs act on rising edge, not level.
// RULE12: Command input source should hold each pulse at least 60 ms.
// RULE13: Local mode accepts panel control and rejects serial-remote control.
// RULE14: Remote mode rejects panel control and accepts serial-remote control.
// RULE15: Local/remote mode comes from panel setting or one digital input.
// RULE16: Virtual inputs obey local/remote check unless bypassed per input.
// RULE17: Setting changes stay permitted in any local/remote mode.
// RULE18: Close button closes, open button opens the object chosen for buttons.
// RULE19: Selective mode needs select then execute; direct mode acts at once.
// RULE20: Release clears all latched outputs and indicators together.
// RULE21: With ready assigned, missing ready at completion expiry is a control failure.
`timescale 1ns/100ps
module sgc_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] open_status_input,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] close_status_input,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] ready_status_input,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] ready_assigned,
	input wire logic [sgc_pkg::TIME_W-1:0] max_pulse_ms,
	input wire logic [sgc_pkg::TIME_W-1:0] compl_ms,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] local_open_in,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] local_close_in,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] remote_open_in,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] remote_close_in,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] virt_open,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] virt_close,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] virt_lr_bypass,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] serial_open,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] serial_close,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] panel_open,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] panel_close,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] aux_open,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] aux_close,
	input wire logic lr_from_input,
	input wire logic lr_panel_remote,
	input wire logic lr_in,
	input wire logic open_button_in,
	input wire logic close_button_in,
	input wire logic execute_button_in,
	input wire logic [sgc_pkg::IDX_W-1:0] object_index,
	input wire logic button_direct,
	input wire logic first_function_key,
	input wire logic release_from_key,
	input wire logic [sgc_pkg::TIME_W-1:0] release_pulse_ms,
	input wire logic release_req,
	input wire logic [sgc_pkg::NUM_OBJ-1:0] latch_set,
	output logic [sgc_pkg::NUM_OBJ-1:0] latched_out,
	output logic release_pulse,
	output logic [sgc_pkg::NUM_OBJ-1:0] obj_open_out,
	output logic [sgc_pkg::NUM_OBJ-1:0] obj_close_out,
	output logic [2*sgc_pkg::NUM_OBJ-1:0] obj_pos,
	output logic [sgc_pkg::NUM_OBJ-1:0] obj_fail,
	output logic [sgc_pkg::NUM_OBJ-1:0] undef_event,
	output logic actuator_fault,
	output logic remote_mode,
	output logic button_selected
);
	localparam int NP = 4 * sgc_pkg::NUM_OBJ + 6;
	// Single pins sit above the four command vectors in the pin group
	localparam int P_REL = 4 * sgc_pkg::NUM_OBJ;
	localparam int P_OPEN = P_REL + 1;
	localparam int P_CLOSE = P_REL + 2;
	localparam int P_EXEC = P_REL + 3;
	localparam int P_KEY = P_REL + 4;

	// Pin group packing: command pins, release pin, buttons, function key and mode pin
	typedef struct packed {
		logic [NP-1:0] s1;
		logic [NP-1:0] s2;
		logic [NP-1:0] prev;
		logic [sgc_pkg::NUM_OBJ-1:0] vo_prev;
		logic [sgc_pkg::NUM_OBJ-1:0] vc_prev;
		logic [sgc_pkg::NUM_OBJ-1:0] st_open;
		logic [sgc_pkg::NUM_OBJ-1:0] st_close;
		logic [sgc_pkg::NUM_OBJ-1:0] st_ready;
		logic [sgc_pkg::NUM_OBJ-1:0] st_open1;
		logic [sgc_pkg::NUM_OBJ-1:0] st_close1;
		logic [sgc_pkg::NUM_OBJ-1:0] st_ready1;
		logic [sgc_pkg::MS_CNT_W-1:0] div;
		logic tick;
		logic sel_valid;
		logic sel_close;
		logic [sgc_pkg::IDX_W-1:0] sel_idx;
		logic rel_active;
		logic [sgc_pkg::TIME_W-1:0] rel_ms;
		logic [sgc_pkg::NUM_OBJ-1:0] latched;
	} sgc_top_s;
	sgc_top_s r, next_r;

	logic [NP-1:0] pins;
	logic [NP-1:0] rise;
	logic remote;
	logic [sgc_pkg::NUM_OBJ-1:0] cmd_o, cmd_c, btn_o, btn_c;
	logic [sgc_pkg::NUM_OBJ-1:0] v_rise_o, v_rise_c, v_ok;
	logic [sgc_pkg::NUM_OBJ-1:0] f_open, f_close, f_undef;
	sgc_pkg::sgc_pos_t f_pos [sgc_pkg::NUM_OBJ];

	assign pins = {lr_in, first_function_key, execute_button_in, close_button_in,
		open_button_in, release_req, remote_close_in, remote_open_in,
		local_close_in, local_open_in};
	assign rise = r.s2 & ~r.prev; // RULE11

	// Mode from one digital input or the panel setting
	assign remote = lr_from_input ? r.s2[NP-1] : lr_panel_remote; // RULE15

	function automatic logic [sgc_pkg::NUM_OBJ-1:0] sgc_onehot(
		input logic [sgc_pkg::IDX_W-1:0] idx);
		sgc_onehot = sgc_pkg::NUM_OBJ'(1) << idx;
	endfunction

	always_comb begin
		btn_o = '0;
		btn_c = '0;
		// Buttons are front panel controls, refused in remote mode
		if (!remote) begin // RULE13
			if (button_direct) begin
				btn_o = rise[P_OPEN] ? sgc_onehot(object_index) : '0; // RULE19
				btn_c = rise[P_CLOSE] ? sgc_onehot(object_index) : '0; // RULE18
			end else if (r.sel_valid && rise[P_EXEC]) begin
				btn_o = r.sel_close ? '0 : sgc_onehot(r.sel_idx); // RULE19
				btn_c = r.sel_close ? sgc_onehot(r.sel_idx) : '0; // RULE18
			end
		end
	end

	assign v_rise_o = virt_open & ~r.vo_prev;
	assign v_rise_c = virt_close & ~r.vc_prev;
	assign v_ok = virt_lr_bypass | {sgc_pkg::NUM_OBJ{remote}}; // RULE16

	// Local pins and panel act only locally; remote pins and serial only remotely
	assign cmd_o = (remote ? (rise[2*sgc_pkg::NUM_OBJ +: sgc_pkg::NUM_OBJ] | serial_open) // RULE10
		: (rise[0 +: sgc_pkg::NUM_OBJ] | panel_open)) | btn_o | (v_rise_o & v_ok) | aux_open; // RULE14
	assign cmd_c = (remote ? (rise[3*sgc_pkg::NUM_OBJ +: sgc_pkg::NUM_OBJ] | serial_close) // RULE10
		: (rise[sgc_pkg::NUM_OBJ +: sgc_pkg::NUM_OBJ] | panel_close)) | btn_c | (v_rise_c & v_ok) | aux_close; // RULE13

	always_comb begin
		next_r = r;
		next_r.s1 = pins;
		next_r.s2 = r.s1;
		next_r.prev = r.s2;
		next_r.vo_prev = virt_open;
		next_r.vc_prev = virt_close;
		next_r.st_open1 = open_status_input;
		next_r.st_close1 = close_status_input;
		next_r.st_ready1 = ready_status_input;
		next_r.st_open = r.st_open1;
		next_r.st_close = r.st_close1;
		next_r.st_ready = r.st_ready1;
		next_r.tick = 1'b0;
		if (r.div == sgc_pkg::MS_TICK_LAST) begin
			next_r.div = '0;
			next_r.tick = 1'b1;
		end else begin
			next_r.div = r.div + 17'h00001;
		end
		// Selective buttons: open/close selects, execute confirms, remote drops it
		if (remote || button_direct) begin
			next_r.sel_valid = 1'b0;
		end else if (rise[P_OPEN] || rise[P_CLOSE]) begin
			next_r.sel_valid = 1'b1; // RULE19
			next_r.sel_close = rise[P_CLOSE];
			next_r.sel_idx = object_index;
		end else if (rise[P_EXEC]) begin
			next_r.sel_valid = 1'b0;
		end
		// Release pulse timing
		if (r.rel_active) begin
			if (r.tick) begin
				next_r.rel_ms = r.rel_ms + 20'h00001;
			end
			if (r.rel_ms >= release_pulse_ms) begin
				next_r.rel_active = 1'b0;
			end
		end else if (|r.latched && ((release_from_key && rise[P_KEY])
			|| rise[P_REL])) begin // RULE2
			next_r.rel_active = 1'b1; // RULE1
			next_r.rel_ms = '0;
		end
		// Set wins over release so a fresh event is not lost
		next_r.latched = (r.rel_active ? '0 : r.latched) | latch_set; // RULE20
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	genvar g;
	generate
		for (g = 0; g < sgc_pkg::NUM_OBJ; g++) begin : g_obj // RULE3
			sgc_obj_if oif ();
			assign oif.cmd_open = cmd_o[g];
			assign oif.cmd_close = cmd_c[g];
			assign oif.ms_tick = r.tick;
			assign oif.max_pulse_ms = max_pulse_ms; // RULE17
			assign oif.compl_ms = compl_ms;
			assign oif.ready_assigned = ready_assigned[g];
			assign oif.open_status_input = r.st_open[g];
			assign oif.close_status_input = r.st_close[g];
			assign oif.ready_status_input = r.st_ready[g];
			sgc_object u_obj (
				.clk(clk),
				.rst_n(rst_n),
				.bus(oif.obj)
			);
			assign f_open[g] = oif.open_out;
			assign f_close[g] = oif.close_out;
			assign f_undef[g] = oif.undef_event;
			assign obj_fail[g] = oif.fail;
			assign f_pos[g] = oif.pos;
			assign obj_pos[2*g +: 2] = f_pos[g];
		end
	endgenerate

	assign obj_open_out = f_open;
	assign obj_close_out = f_close;
	assign undef_event = f_undef;
	assign actuator_fault = |obj_fail; // RULE4
	assign latched_out = r.latched;
	assign release_pulse = r.rel_active;
	assign remote_mode = remote;
	assign button_selected = r.sel_valid;

	property p_fault_any;
		@(posedge clk) disable iff (!rst_n)
		|undef_event |-> actuator_fault;
	endproperty
	a_fault_any: assert property (p_fault_any) else $error("fault output missing"); // RULE4

	property p_release_needs_latch;
		@(posedge clk) disable iff (!rst_n)
		$rose(release_pulse) |-> $past(|latched_out);
	endproperty
	a_release_needs_latch: assert property (p_release_needs_latch) else $error("release w/o latch"); // RULE2

	property p_release_clears;
		@(posedge clk) disable iff (!rst_n)
		(release_pulse && latch_set == '0) |=> latched_out == '0;
	endproperty
	a_release_clears: assert property (p_release_clears) else $error("latches not cleared"); // RULE20

	property p_remote_blocks_local;
		@(posedge clk) disable iff (!rst_n)
		(remote && rise[2*sgc_pkg::NUM_OBJ +: sgc_pkg::NUM_OBJ] == '0 && virt_open == '0
			&& aux_open == '0 && serial_open == '0) |-> cmd_o == '0;
	endproperty
	a_remote_blocks_local: assert property (p_remote_blocks_local) else $error("local in remote"); // RULE10

	property p_local_only;
		@(posedge clk) disable iff (!rst_n)
		(!remote && rise[0 +: sgc_pkg::NUM_OBJ] == '0 && panel_open == '0 && btn_o == '0
			&& virt_open == '0 && aux_open == '0) |-> cmd_o == '0;
	endproperty
	a_local_only: assert property (p_local_only) else $error("remote in local"); // RULE10

	property p_panel_local;
		@(posedge clk) disable iff (!rst_n)
		!remote |-> (cmd_o & panel_open) == panel_open;
	endproperty
	a_panel_local: assert property (p_panel_local) else $error("panel refused"); // RULE13

	property p_serial_remote;
		@(posedge clk) disable iff (!rst_n)
		remote |-> (cmd_c & serial_close) == serial_close;
	endproperty
	a_serial_remote: assert property (p_serial_remote) else $error("serial refused"); // RULE14

	property p_mode_pin;
		@(posedge clk) disable iff (!rst_n)
		(lr_from_input && $past(rst_n, 2)) |-> remote_mode == $past(lr_in, 2);
	endproperty
	a_mode_pin: assert property (p_mode_pin) else $error("mode pin ignored"); // RULE15

	// Pins are two stages late, so the edge is judged on their past values
	property p_cmd_edge;
		@(posedge clk) disable iff (!rst_n)
		$past(rst_n, 3) |-> rise[sgc_pkg::NUM_OBJ +: sgc_pkg::NUM_OBJ]
			== ($past(local_close_in, 2) & ~$past(local_close_in, 3));
	endproperty
	a_cmd_edge: assert property (p_cmd_edge) else $error("command not on edge"); // RULE11

	property p_status_sync;
		@(posedge clk) disable iff (!rst_n)
		$past(rst_n, 2) |-> obj_pos[1:0] == sgc_pkg::sgc_decode(
			$past(open_status_input[0], 2), $past(close_status_input[0], 2));
	endproperty
	a_status_sync: assert property (p_status_sync) else $error("position not synced"); // RULE5

	property p_open_close_excl;
		@(posedge clk) disable iff (!rst_n)
		(obj_open_out & obj_close_out) == '0;
	endproperty
	a_open_close_excl: assert property (p_open_close_excl) else $error("open and close"); // RULE9

	property p_sel_set;
		@(posedge clk) disable iff (!rst_n)
		(!remote && !button_direct && (rise[P_OPEN] || rise[P_CLOSE])) |=> button_selected;
	endproperty
	a_sel_set: assert property (p_sel_set) else $error("select lost"); // RULE19

	property p_sel_clear;
		@(posedge clk) disable iff (!rst_n)
		(remote || button_direct) |=> !button_selected;
	endproperty
	a_sel_clear: assert property (p_sel_clear) else $error("select kept"); // RULE19

	property p_exec_needs_sel;
		@(posedge clk) disable iff (!rst_n)
		(!button_direct && !button_selected) |-> btn_o == '0 && btn_c == '0;
	endproperty
	a_exec_needs_sel: assert property (p_exec_needs_sel) else $error("unselected execute"); // RULE18

	property p_release_key;
		@(posedge clk) disable iff (!rst_n)
		(!release_pulse && |latched_out && release_from_key && rise[P_KEY]) |=> release_pulse;
	endproperty
	a_release_key: assert property (p_release_key) else $error("key release missed"); // RULE1

	property p_release_len;
		@(posedge clk) disable iff (!rst_n)
		(release_pulse && r.rel_ms < release_pulse_ms) |=> release_pulse;
	endproperty
	a_release_len: assert property (p_release_len) else $error("release too short"); // RULE1

	property p_latch_hold;
		@(posedge clk) disable iff (!rst_n)
		!release_pulse |=> latched_out == ($past(latched_out) | $past(latch_set));
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latch not held"); // RULE20
endmodule

// ### sgc_aux_model.sv
// Behavioural model of eight objects' auxiliary open, close and ready contacts.
// Assumes command outputs stay high until the position leaves its start code.
`timescale 1ns/100ps
module sgc_aux_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] open_cmd,
	input wire logic [7:0] close_cmd,
	input wire logic slow,
	input wire logic [7:0] stuck,
	output logic [7:0] open_st,
	output logic [7:0] close_st,
	output logic [7:0] ready_st
);
	logic [7:0] op, cl, tgt, mov;
	int cnt [8];
	// A welded mechanism shows both contacts made, position code 11
	assign open_st = op | stuck;
	assign close_st = cl | stuck;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			op <= 8'hFF;
			cl <= 8'h00;
			mov <= 8'h00;
			ready_st <= 8'hFF;
		end else begin
			for (int g = 0; g < 8; g++) begin
				if (!mov[g] && (open_cmd[g] || close_cmd[g])) begin
					mov[g] <= 1'b1;
					tgt[g] <= close_cmd[g];
					cnt[g] <= slow ? 40 : 10;
				end else if (mov[g]) begin
					cnt[g] <= cnt[g] - 1;
					// Both contacts break mid-travel, so the code passes through 00
					if (cnt[g] == 4) begin
						op[g] <= 1'b0;
						cl[g] <= 1'b0;
						ready_st[g] <= 1'b0;
					end
					if (cnt[g] == 0) begin
						mov[g] <= 1'b0;
						op[g] <= !tgt[g];
						cl[g] <= tgt[g];
						ready_st[g] <= 1'b1;
					end
				end
			end
		end
	end
endmodule

// ### sgc_top_tb.sv
// Self-checking bench for the switchgear object control block.
// Assumes the contact model above; timeouts expire only through zero limits to keep runs short.
`timescale 1ns/100ps
module sgc_top_tb;
	localparam logic [5:0] ACC_L = 6'h35;
	localparam logic [5:0] ACC_R = 6'h2E;
	localparam logic [7:0] RDY = 8'h0F;
	logic clk, rst_n, slow, lr_from_input, lr_panel_remote, lr_in, button_direct, release_from_key;
	logic [7:0] so [6];
	logic [7:0] sc [6];
	logic [4:0] btn;
	logic [7:0] stuck, latch_set, st, byp;
	logic [19:0] max_ms, cpl_ms;
	logic [7:0] open_st, close_st, ready_st, latched_out, obj_open_out, obj_close_out;
	logic [7:0] obj_fail, undef_event;
	logic [15:0] obj_pos;
	logic [2:0] object_index;
	logic release_pulse, actuator_fault, remote_mode, button_selected;
	int n_mismatch, compares;
	sgc_top u_sgc_top (.clk(clk), .rst_n(rst_n), .open_status_input(open_st),
		.close_status_input(close_st), .ready_status_input(ready_st),
		.ready_assigned(RDY), .max_pulse_ms(max_ms), .compl_ms(cpl_ms),
		.local_open_in(so[0]), .local_close_in(sc[0]), .remote_open_in(so[1]),
		.remote_close_in(sc[1]), .virt_open(so[2]), .virt_close(sc[2]),
		.virt_lr_bypass(byp), .serial_open(so[3]), .serial_close(sc[3]),
		.panel_open(so[4]), .panel_close(sc[4]), .aux_open(so[5]), .aux_close(sc[5]),
		.lr_from_input(lr_from_input), .lr_panel_remote(lr_panel_remote), .lr_in(lr_in),
		.open_button_in(btn[0]), .close_button_in(btn[1]), .execute_button_in(btn[2]),
		.object_index(object_index), .button_direct(button_direct),
		.first_function_key(btn[4]), .release_from_key(release_from_key),
		.release_pulse_ms(20'h00001), .release_req(btn[3]), .latch_set(latch_set),
		.latched_out(latched_out), .release_pulse(release_pulse),
		.obj_open_out(obj_open_out), .obj_close_out(obj_close_out), .obj_pos(obj_pos),
		.obj_fail(obj_fail), .undef_event(undef_event), .actuator_fault(actuator_fault),
		.remote_mode(remote_mode), .button_selected(button_selected));
	sgc_aux_model u_sgc_aux_model (.clk(clk), .rst_n(rst_n), .open_cmd(obj_open_out),
		.close_cmd(obj_close_out), .slow(slow), .stuck(stuck), .open_st(open_st),
		.close_st(close_st), .ready_st(ready_st));

	task check(input string nm, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task close_out;
		if (n_mismatch == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task wait_out(input int g, input logic cl, input logic want, input int lim, output bit hit);
		hit = 0;
		for (int i = 0; i < lim && !hit; i++) begin
			@(negedge clk);
			hit = ((cl ? obj_close_out[g] : obj_open_out[g]) === want);
		end
	endtask

	// Pins are held only a few cycles; the two-stage sync needs no more
	task fire(input int s, input int g, input logic cl);
		@(negedge clk);
		if (cl)
			sc[s][g] = 1'b1;
		else
			so[s][g] = 1'b1;
		repeat (s < 2 ? 5 : 1) @(negedge clk);
		sc[s][g] = 1'b0;
		so[s][g] = 1'b0;
	endtask

	task pin(input int b);
		btn[b] = 1'b1;
		repeat (5) @(negedge clk);
		btn[b] = 1'b0;
	endtask

	task follow(input int g, input logic cl, input logic acc);
		bit hit;
		wait_out(g, cl, 1'b1, 14, hit);
		check("cmd_out", {15'h0, acc}, {15'h0, hit});
		if (hit) begin
			wait_out(g, cl, 1'b0, 60, hit);
			check("cmd_end", 16'h1, {15'h0, hit});
			repeat (12) @(negedge clk);
			check("pos", {14'h0, cl ? 2'h2 : 2'h1}, {14'h0, obj_pos[2*g +: 2]});
			check("fail", {15'h0, cpl_ms == 20'h0 && RDY[g]}, {15'h0, obj_fail[g]});
			st[g] = cl;
		end
	endtask

	task cmd(input int s, input int g, input logic cl, input logic acc);
		fire(s, g, cl);
		follow(g, cl, acc);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		close_out;
	end

	initial begin
		{rst_n, slow, lr_from_input, lr_panel_remote, lr_in, button_direct} = '0;
		{btn, stuck, latch_set, st, object_index, release_from_key} = '0;
		{byp, max_ms, cpl_ms} = {8'hFF, 20'h00014, 20'h00014};
		for (int s = 0; s < 6; s++) begin
			so[s] = 8'h00;
			sc[s] = 8'h00;
		end
		repeat (4) @(negedge clk);
		check("rst_pos", 16'h0000, obj_pos);
		check("rst_out", 16'h0000, {obj_open_out, obj_close_out});
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		check("pos_open", 16'h5555, obj_pos);
		// Remote pass runs the contacts slowly so the pulse is held long
		for (int m = 0; m < 2; m++) begin
			lr_panel_remote = m[0];
			slow = m[0];
			for (int s = 0; s < 6; s++)
				cmd(s, s, !st[s], m ? ACC_R[s] : ACC_L[s]);
		end
		cmd(5, 2, 1'b0, 1'b0);
		lr_panel_remote = 1'b0;
		sc[0][6] = 1'b1;
		follow(6, 1'b1, 1'b1);
		cmd(5, 6, 1'b0, 1'b1);
		follow(6, 1'b1, 1'b0);
		sc[0][6] = 1'b0;
		object_index = 3'h7;
		pin(1);
		repeat (6) @(negedge clk);
		check("selected", 16'h1, {15'h0, button_selected});
		check("no_exec", 16'h0, {15'h0, obj_close_out[7]});
		pin(2);
		follow(7, 1'b1, 1'b1);
		button_direct = 1'b1;
		pin(0);
		follow(7, 1'b0, 1'b1);
		lr_panel_remote = 1'b1;
		pin(1);
		follow(7, 1'b1, 1'b0);
		lr_from_input = 1'b1;
		lr_in = 1'b0;
		repeat (6) @(negedge clk);
		check("lr_pin", 16'h0, {15'h0, remote_mode});
		lr_in = 1'b1;
		lr_panel_remote = 1'b0;
		repeat (6) @(negedge clk);
		check("lr_pin", 16'h1, {15'h0, remote_mode});
		lr_from_input = 1'b0;
		stuck[4] = 1'b1;
		repeat (4) @(negedge clk);
		check("pos_11", 16'h3, {14'h0, obj_pos[9:8]});
		stuck[4] = 1'b0;
		check("fault", 16'h0, {15'h0, actuator_fault});
		// A zero limit expires on the first cycle, so expiry needs no long wait
		max_ms = 20'h00000;
		fire(5, 3, 1'b0);
		@(negedge clk);
		check("undef_evt", 16'h0008, {8'h0, undef_event});
		check("fail_flag", 16'h0008, {8'h0, obj_fail});
		check("fault_on", 16'h1, {15'h0, actuator_fault});
		check("out_cut", 16'h0, {15'h0, obj_open_out[3]});
		max_ms = 20'h00014;
		cpl_ms = 20'h00000;
		cmd(5, 0, 1'b0, 1'b1);
		cmd(5, 5, 1'b1, 1'b1);
		cpl_ms = 20'h00014;
		byp = 8'h00;
		cmd(2, 4, 1'b0, 1'b0);
		pin(3);
		repeat (8) @(negedge clk);
		check("rel_idle", 16'h0, {15'h0, release_pulse});
		latch_set = 8'hA5;
		@(negedge clk);
		latch_set = 8'h00;
		@(negedge clk);
		check("latched", 16'h00A5, {8'h0, latched_out});
		pin(4);
		repeat (8) @(negedge clk);
		check("key_unsel", 16'h00A5, {8'h0, latched_out});
		release_from_key = 1'b1;
		pin(4);
		repeat (6) @(negedge clk);
		check("rel_pulse", 16'h1, {15'h0, release_pulse});
		check("released", 16'h0, {8'h0, latched_out});
		close_out;
	end
endmodule
